// file: common/cbc_pkg.sv
// Shared constants and types for the processor bus, clock and reset pin block
// How it works
// RQ1 - Shared 32-bit bus carries addresses and data
// RQ2 - 5-bit bus carries command or data tag
// RQ3 - Agent valid marks its driven words
// RQ4 - Processor valid marks exactly its driven words
// RQ5 - Agent raises request to use interface
// RQ6 - Processor raises request when it needs bus
// RQ7 - Protocol error: request toggles, interface halts
// RQ8 - Ownership output high while processor controls
// RQ9 - Agent accept only when request can proceed
// RQ10 - Interrupt levels visible as cause bits 14:10
// RQ11 - Non-maskable interrupt is never masked
// RQ12 - Cold reset initialises everything, asynchronously
// RQ13 - Warm reset raises exception, keeps state
// RQ14 - Interface clock output follows reference clock
// RQ15 - Deskew clock driven out and returned in
// RQ16 - Unused scan clock held low outside
// RQ17 - Two-bit ratio select decodes base ratios
// RQ18 - Three-bit code 010 gives 2:5:2, fast only
// RQ19 - Board loops deskew out to in shortest
// RQ20 - Ratio select pins are static straps
package cbc_pkg;
    localparam int AD_W    = 32;
    localparam int CMD_W   = 5;
    localparam int INT_W   = 5;
    localparam int CAUSE_LSB = 10;   // Interrupt levels sit at cause bits 14:10
    localparam int SEL_W   = 3;
    localparam int MULT_W  = 3;
    localparam int DIV_W   = 2;

    // Gray-coded bus ownership states
    typedef enum logic [1:0] {
        CBC_IDLE = 2'b00,
        CBC_REQ  = 2'b01,
        CBC_OWN  = 2'b11,
        CBC_HANG = 2'b10
    } cbc_state_t;

    // Reset values of pin outputs
    localparam logic [AD_W-1:0]  AD_RST  = 32'h0000_0000;
    localparam logic [CMD_W-1:0] CMD_RST = 5'h00;
endpackage : cbc_pkg

// file: common/cbc_clk_if.sv
// Status carried from the clock generator to the bus logic
`timescale 1ns/1ps
interface cbc_clk_if;
    logic tick;      // One cycle per internal interface clock period
    logic locked;    // Returned deskew clock matches the driven one
    logic ratio_ok;  // Captured ratio code is legal for this grade
    modport gen (output tick, output locked, output ratio_ok);
    modport use_side (input tick, input locked, input ratio_ok);
endinterface : cbc_clk_if

// file: src/cbc_clkgen.sv
// Interface clock, deskew loop and ratio strap decode
`timescale 1ns/1ps
module cbc_clkgen
    import cbc_pkg::*;
#(
    parameter bit FAST_GRADE = 1'b1,  // Fastest speed grade allows code 00 instead of 01 on the narrow select, and also code 010 on the wide one
    parameter bit WIDE_SEL   = 1'b0   // Three-bit ratio select variant
) (
    input  wire logic             clock,          // Reference clock
    input  wire logic             reset_n,        // Cold reset, active low
    input  wire logic [SEL_W-1:0] ratio_select,   // Ratio strap pins
    input  wire logic             deskew_clk_in,  // Returned deskew clock
    output logic                  iface_clock,    // Interface clock pin
    output logic                  deskew_clk_out, // Deskew clock pin
    output logic [MULT_W-1:0]     pipe_mult,      // Pipeline side of ratio
    output logic [DIV_W-1:0]      ref_div,        // Reference side of ratio
    cbc_clk_if.gen                ck              // Status to bus logic
);
    logic              tgl_q;
    logic              cap_q;
    logic [2:0]        dsk_q;
    logic [1:0]        out_hist_q;
    logic [MULT_W-1:0] mult_d;
    logic [DIV_W-1:0]  div_d;
    logic              ok_d;
    logic [SEL_W-1:0]  code;

    // Narrow variant ignores the top strap bit
    assign code = WIDE_SEL ? ratio_select : {1'b0, ratio_select[1:0]};

    // Ratio decode; reserved codes report as not ok
    always_comb begin
        mult_d = 3'h2;
        div_d  = 2'h1;
        ok_d   = 1'b1;
        if (!WIDE_SEL) begin
            case (code[1:0])
                2'b00: begin mult_d = 3'h4; ok_d = FAST_GRADE; end  // RQ17
                2'b01: begin mult_d = 3'h3; div_d = 2'h2; ok_d = !FAST_GRADE; end
                2'b10: mult_d = 3'h2;                                // RQ17
                2'b11: mult_d = 3'h3;                                // RQ17
                default: ok_d = 1'b0;
            endcase
        end else begin
            case (code)
                3'b000: mult_d = 3'h5;
                3'b001: mult_d = 3'h6;
                3'b010: begin mult_d = 3'h5; div_d = 2'h2; ok_d = FAST_GRADE; end  // RQ18
                3'b011: mult_d = 3'h3;
                3'b100: mult_d = 3'h4;
                3'b110: mult_d = 3'h2;
                3'b111: mult_d = 3'h3;
                default: ok_d = 1'b0;
            endcase
        end
    end

    // Strap caught once after reset release; later pin changes are ignored
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cap_q       <= 1'b0;
            pipe_mult   <= 3'h0;
            ref_div     <= 2'h0;
            ck.ratio_ok <= 1'b0;
        end else if (!cap_q) begin
            cap_q       <= 1'b1;            // RQ20
            pipe_mult   <= mult_d;
            ref_div     <= div_d;
            ck.ratio_ok <= ok_d;
        end
    end

    // Interface clock toggles on every rising reference edge, phase tied to it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tgl_q          <= 1'b0;
            iface_clock    <= 1'b0;
            deskew_clk_out <= 1'b0;
            ck.tick        <= 1'b0;
        end else begin
            tgl_q          <= !tgl_q;       // RQ14
            iface_clock    <= !tgl_q;       // RQ14
            deskew_clk_out <= !tgl_q;       // RQ15
            ck.tick        <= !tgl_q;
        end
    end

    // Returned clock is synchronised, then compared with what was sent
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dsk_q      <= 3'h0;
            out_hist_q <= 2'h0;
            ck.locked  <= 1'b0;
        end else begin
            dsk_q      <= {dsk_q[1:0], deskew_clk_in};     // RQ15
            out_hist_q <= {out_hist_q[0], deskew_clk_out};
            ck.locked  <= (dsk_q[1] == out_hist_q[1]) && (dsk_q[2] != dsk_q[1]);
        end
    end
endmodule : cbc_clkgen

// file: src/cbc_top.sv
// Processor system interface pins: bus handshakes, interrupts, resets and clocks
`timescale 1ns/1ps
module cbc_top
    import cbc_pkg::*;
#(
    parameter bit FAST_GRADE = 1'b1,  // Fastest speed grade
    parameter bit WIDE_SEL   = 1'b0   // Three-bit ratio select variant
) (
    input  wire logic             clock,             // Reference input clock
    input  wire logic             reset_n,           // Cold reset, asynchronous
    input  wire logic             warm_reset_n,      // Warm reset pin
    input  wire logic [SEL_W-1:0] ratio_select,      // Ratio straps
    input  wire logic             deskew_clk_in,     // Returned deskew clock
    output logic                  iface_clock,       // Interface clock pin
    output logic                  deskew_clk_out,    // Deskew clock pin
    output logic [MULT_W-1:0]     pipe_mult,         // Pipeline ratio term
    output logic [DIV_W-1:0]      ref_div,           // Reference ratio term
    output logic                  ratio_bad_q,       // Reserved ratio code seen
    input  wire logic [AD_W-1:0]  ad_in,             // Address/data bus in
    output logic [AD_W-1:0]       ad_out_q,          // Address/data bus out
    output logic                  ad_oe_q,           // Address/data drive enable
    input  wire logic [CMD_W-1:0] cmd_in,            // Command bus in
    output logic [CMD_W-1:0]      cmd_out_q,         // Command bus out
    output logic                  cmd_oe_q,          // Command drive enable
    input  wire logic             agent_drive_valid, // Agent drives valid word
    input  wire logic             agent_bus_request, // Agent wants the bus
    input  wire logic             agent_accept_ok,   // Agent can take request
    output logic                  cpu_drive_valid_q, // Processor word valid
    output logic                  cpu_bus_request_q, // Processor request
    output logic                  cpu_owns_bus_q,    // Processor is master
    output logic                  protocol_error_q,  // Interface hung
    input  wire logic [INT_W-1:0] int_req,           // Interrupt pins
    input  wire logic [INT_W-1:0] int_mask,          // Enables from core
    input  wire logic             nmi_req,           // Non-maskable interrupt pin
    output logic [INT_W-1:0]      cause_ip_q,        // Cause bits 14:10
    output logic                  int_pending_q,     // Unmasked interrupt level
    output logic                  nmi_event_q,       // NMI edge pulse
    output logic                  reset_exc_q,       // Warm reset exception pulse
    input  wire logic             tx_valid,          // Core has word to send
    input  wire logic [AD_W-1:0]  tx_word,           // Word to send
    input  wire logic [CMD_W-1:0] tx_cmd,            // Command or data tag
    input  wire logic             tx_last,           // Final word of transfer
    output logic                  tx_take_q,         // Word taken pulse
    output logic                  rx_valid_q,        // Word received pulse
    output logic [AD_W-1:0]       rx_word_q,         // Received word
    output logic [CMD_W-1:0]      rx_cmd_q           // Received command or tag
);
    cbc_clk_if ck ();

    cbc_clkgen #(
        .FAST_GRADE (FAST_GRADE),
        .WIDE_SEL   (WIDE_SEL)
    ) u_clkgen (
        .clock          (clock),
        .reset_n        (reset_n),
        .ratio_select   (ratio_select),
        .deskew_clk_in  (deskew_clk_in),
        .iface_clock    (iface_clock),
        .deskew_clk_out (deskew_clk_out),
        .pipe_mult      (pipe_mult),
        .ref_div        (ref_div),
        .ck             (ck)
    );

    // Two-flop synchronisers for the bus, command, interrupt, NMI, warm reset and agent handshake pins; stage one feeds stage two only
    localparam int SW = AD_W + CMD_W + INT_W + 5;
    logic [SW-1:0] s1_q;
    logic [SW-1:0] s2_q;
    logic [SW-1:0] pins;
    assign pins = {ad_in, cmd_in, int_req, nmi_req, warm_reset_n,
                   agent_drive_valid, agent_bus_request, agent_accept_ok};
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= '0;                                                // RQ12
            s2_q <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
        end
    end

    // Named views of synchronised pins
    logic [AD_W-1:0]  ad_s;
    logic [CMD_W-1:0] cmd_s;
    logic [INT_W-1:0] int_s;
    logic             nmi_s;
    logic             warm_s;
    logic             agent_drive_valid_s;
    logic             agent_bus_request_s;
    logic             eok_s;
    assign {ad_s, cmd_s, int_s, nmi_s, warm_s, agent_drive_valid_s, agent_bus_request_s, eok_s} = s2_q;

    // Interrupts, NMI and warm reset; NMI ignores the mask entirely
    logic nmi_q;
    logic warm_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            nmi_q         <= 1'b0;
            warm_q        <= 1'b0;    // Same as the synchroniser, so no false exception after cold reset
            cause_ip_q    <= '0;
            int_pending_q <= 1'b0;
            nmi_event_q   <= 1'b0;
            reset_exc_q   <= 1'b0;
        end else begin
            nmi_q         <= nmi_s;
            warm_q        <= warm_s;
            cause_ip_q    <= int_s;                   // RQ10
            int_pending_q <= |(int_s & int_mask);
            nmi_event_q   <= nmi_s && !nmi_q;         // RQ11
            reset_exc_q   <= warm_q && !warm_s;       // RQ13
        end
    end

    // Bus ownership decode
    cbc_state_t st_q;
    logic       last_q;
    logic       run;
    logic       grant;
    logic       bad_drive;
    assign run       = ck.locked && ck.ratio_ok;
    assign grant     = eok_s && !agent_bus_request_s;                              // RQ9
    assign bad_drive = agent_drive_valid_s && (st_q == CBC_OWN);                  // RQ7

    // Ownership machine; steps happen on interface clock ticks, except the jump to CBC_HANG on a bad drive
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q   <= CBC_IDLE;
            last_q <= 1'b0;
        end else if (bad_drive) begin
            st_q   <= CBC_HANG;                                        // RQ7
        end else if (ck.tick) begin
            case (st_q)
                CBC_IDLE: if (tx_valid && run) begin
                    st_q <= CBC_REQ;                                   // RQ6
                end
                CBC_REQ:  if (grant) begin
                    st_q <= CBC_OWN;
                end
                CBC_OWN:  if (last_q) begin
                    st_q   <= CBC_IDLE;
                    last_q <= 1'b0;
                end else if (tx_valid) begin
                    last_q <= tx_last;
                end
                CBC_HANG: st_q <= CBC_HANG;                            // Only cold reset leaves
                default:  st_q <= CBC_IDLE;
            endcase
        end
    end

    // Pin drivers follow the state; a hung interface only toggles its request
    logic drive;
    assign drive = ck.tick && (st_q == CBC_OWN) && !last_q && tx_valid && !bad_drive;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cpu_bus_request_q <= 1'b0;
            cpu_owns_bus_q    <= 1'b0;
            protocol_error_q  <= 1'b0;
            ratio_bad_q       <= 1'b0;
        end else begin
            ratio_bad_q      <= !ck.ratio_ok;
            protocol_error_q <= protocol_error_q || bad_drive;
            cpu_owns_bus_q   <= (st_q == CBC_OWN) && !bad_drive &&
                                !(ck.tick && last_q);                  // RQ8
            if (st_q == CBC_HANG) begin
                cpu_bus_request_q <= cpu_bus_request_q ^ ck.tick;      // RQ7
            end else begin
                cpu_bus_request_q <= (st_q == CBC_REQ) && !(ck.tick && grant); // RQ6
            end
        end
    end

    // Word drive and capture
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ad_out_q          <= AD_RST;
            cmd_out_q         <= CMD_RST;
            ad_oe_q           <= 1'b0;
            cmd_oe_q          <= 1'b0;
            cpu_drive_valid_q <= 1'b0;
            tx_take_q         <= 1'b0;
            rx_valid_q        <= 1'b0;
            rx_word_q         <= AD_RST;
            rx_cmd_q          <= CMD_RST;
        end else begin
            tx_take_q  <= drive;
            rx_valid_q <= ck.tick && agent_drive_valid_s && (st_q != CBC_OWN) && (st_q != CBC_HANG); // RQ3
            if (ck.tick && agent_drive_valid_s) begin
                rx_word_q <= ad_s;
                rx_cmd_q  <= cmd_s;
            end
            if (drive) begin
                ad_out_q  <= tx_word;                                  // RQ1
                cmd_out_q <= tx_cmd;                                   // RQ2
            end
            if (ck.tick || bad_drive) begin
                cpu_drive_valid_q <= drive;                            // RQ4
                ad_oe_q           <= (st_q == CBC_OWN) && !last_q && !bad_drive;  // RQ1
                cmd_oe_q          <= (st_q == CBC_OWN) && !last_q && !bad_drive;  // RQ2
            end
        end
    end

    // Checks on the driven pins
    sequence own_seq;
        cpu_owns_bus_q;
    endsequence

    valid_needs_own_a: assert property (@(posedge clock) disable iff (!reset_n)
        cpu_drive_valid_q |-> own_seq and ad_oe_q and cmd_oe_q) // RQ4
        else $error("valid strobe without driving the bus");
    valid_from_take_a: assert property (@(posedge clock) disable iff (!reset_n)
        tx_take_q |-> cpu_drive_valid_q) // RQ4
        else $error("taken word not marked valid");
    hang_toggle_a: assert property (@(posedge clock) disable iff (!reset_n)
        (st_q == CBC_HANG) && $past(st_q == CBC_HANG) && ck.tick |=> cpu_bus_request_q != $past(cpu_bus_request_q)) // RQ7
        else $error("request not toggling after protocol error");
    hang_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
        protocol_error_q |-> !cpu_owns_bus_q && !ad_oe_q && !cpu_drive_valid_q && !tx_take_q) // RQ7
        else $error("interface active after protocol error");
    req_then_own_a: assert property (@(posedge clock) disable iff (!reset_n)
        cpu_owns_bus_q && !$past(cpu_owns_bus_q) |-> $past(cpu_bus_request_q, 2)) // RQ8
        else $error("ownership taken without a request");
    cause_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
        ##3 cause_ip_q == $past(int_req, 3)) // RQ10
        else $error("cause bits do not track interrupt pins");
    nmi_unmasked_a: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(nmi_s) |=> nmi_event_q ##1 !nmi_event_q) // RQ11
        else $error("nmi edge not reported once");
    warm_exc_a: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(warm_s) |=> reset_exc_q) // RQ13
        else $error("warm reset gave no exception");
    iface_clk_a: assert property (@(posedge clock) disable iff (!reset_n)
        $past(reset_n) |-> iface_clock != $past(iface_clock) && deskew_clk_out == iface_clock) // RQ14
        else $error("interface clock not following reference");
endmodule : cbc_top

// file: sim/cbc_agent.sv
// Behavioural model of the external agent on the processor system interface
`timescale 1ns/1ps
module cbc_agent
    import cbc_pkg::*;
(
    input  wire logic             clock,             // Reference clock
    input  wire logic [AD_W-1:0]  ad_out_q,          // Processor bus drive
    input  wire logic             ad_oe_q,           // Processor drives bus
    input  wire logic [CMD_W-1:0] cmd_out_q,         // Processor command drive
    input  wire logic             cmd_oe_q,          // Processor drives command
    input  wire logic             cpu_bus_request_q, // Processor request
    input  wire logic             cpu_owns_bus_q,    // Processor is master
    input  wire logic             deskew_clk_out,    // Deskew clock from device
    output logic [AD_W-1:0]       ad_in,             // Bus level seen by device
    output logic [CMD_W-1:0]      cmd_in,            // Command level seen
    output logic                  agent_drive_valid = 1'b0, // Agent word valid
    output logic                  agent_bus_request = 1'b0, // Agent wants bus
    output logic                  agent_accept_ok   = 1'b0, // Agent takes request
    output logic                  deskew_clk_in      // Returned deskew clock
);
    int               accept_lat = 0;  // Cycles of request before accepting
    int               req_cnt    = 0;
    logic             drv_q      = 1'b0;
    logic [AD_W-1:0]  word_q     = 32'h0000_0000;
    logic [CMD_W-1:0] cmd_q      = 5'h00;
    logic [AD_W-1:0]  idle_ad_q  = 32'h0000_0000;
    logic [CMD_W-1:0] idle_cmd_q = 5'h00;

    // Released lines flip every cycle so a stale word can never pass for a capture
    assign ad_in         = ad_oe_q ? ad_out_q : (drv_q ? word_q : idle_ad_q);
    assign cmd_in        = cmd_oe_q ? cmd_out_q : (drv_q ? cmd_q : idle_cmd_q);
    assign deskew_clk_in = deskew_clk_out;

    // Accept only after the chosen latency and never while wanting the bus itself
    always @(posedge clock) begin
        idle_ad_q       <= ~ad_in;
        idle_cmd_q      <= ~cmd_in;
        req_cnt         <= cpu_bus_request_q ? req_cnt + 1 : 0;
        agent_accept_ok <= cpu_bus_request_q && req_cnt >= accept_lat && !agent_bus_request;
    end

    // One word held for a full tick span; bad set drives even while the processor owns
    task automatic send(input logic [AD_W-1:0] w, input logic [CMD_W-1:0] c, input bit bad);
        int i;
        @(posedge clock);
        agent_bus_request <= 1'b1;
        for (i = 0; i < 50 && cpu_owns_bus_q === 1'b1 && !bad; i++) begin
            @(posedge clock);
        end
        drv_q             <= 1'b1;
        word_q            <= w;
        cmd_q             <= c;
        agent_drive_valid <= 1'b1;
        repeat (2) @(posedge clock);
        drv_q             <= 1'b0;
        agent_drive_valid <= 1'b0;
        agent_bus_request <= 1'b0;
    endtask : send
endmodule : cbc_agent

// file: sim/cbc_top_bench.sv
// Self-checking bench for the processor bus, clock and reset pin block
`timescale 1ns/1ps
module cbc_top_bench
    import cbc_pkg::*;
;
    logic             clock = 1'b0, reset_n = 1'b0, warm_reset_n = 1'b1, nmi_req = 1'b0;
    logic [SEL_W-1:0] ratio_select = 3'h2;
    logic [INT_W-1:0] int_req = 5'h00, int_mask = 5'h00, cause_ip_q;
    logic             tx_valid = 1'b0, tx_last = 1'b0;
    logic [AD_W-1:0]  tx_word = 32'h0000_0000, ad_in, ad_out_q, rx_word_q;
    logic [CMD_W-1:0] tx_cmd = 5'h00, cmd_in, cmd_out_q, rx_cmd_q;
    logic             iface_clock, deskew_clk_out, deskew_clk_in, ratio_bad_q, ad_oe_q, cmd_oe_q;
    logic             agent_drive_valid, agent_bus_request, agent_accept_ok, cpu_drive_valid_q;
    logic             cpu_bus_request_q, cpu_owns_bus_q, protocol_error_q, int_pending_q;
    logic             nmi_event_q, reset_exc_q, tx_take_q, rx_valid_q;
    logic [MULT_W-1:0] pipe_mult;
    logic [DIV_W-1:0] ref_div;
    int               n_mismatch = 0, cmp_count = 0, edges = 0;

    cbc_top #(.FAST_GRADE(1'b1), .WIDE_SEL(1'b0)) dut (.*);

    cbc_agent agt (
        .clock(clock), .ad_out_q(ad_out_q), .ad_oe_q(ad_oe_q), .cmd_out_q(cmd_out_q), .cmd_oe_q(cmd_oe_q),
        .cpu_bus_request_q(cpu_bus_request_q), .cpu_owns_bus_q(cpu_owns_bus_q),
        .deskew_clk_out(deskew_clk_out), .ad_in(ad_in), .cmd_in(cmd_in),
        .agent_drive_valid(agent_drive_valid), .agent_bus_request(agent_bus_request),
        .agent_accept_ok(agent_accept_ok), .deskew_clk_in(deskew_clk_in));

    // 100 ns reference clock; edges counts rising edges since cold reset was released
    initial begin
        forever #50 clock = ~clock;
    end
    always @(posedge clock) edges <= (reset_n === 1'b1) ? edges + 1 : 0;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    function automatic logic pick(input int w);
        case (w)
            0: pick = cpu_bus_request_q;
            1: pick = tx_take_q;
            2: pick = cpu_owns_bus_q;
            3: pick = rx_valid_q;
            4: pick = nmi_event_q;
            5: pick = reset_exc_q;
            default: pick = protocol_error_q;
        endcase
    endfunction : pick

    // Bounded wait, at least one edge, for the picked output to be high
    task automatic wait_on(input int w, input int lim);
        int i;
        @(posedge clock);
        #1;
        for (i = 0; i < lim && pick(w) !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk("wait_for_output", 32'h1, 32'(pick(w)));
    endtask : wait_on

    // Straps are set while reset is held and never touched afterwards
    task automatic cold_reset(input logic [SEL_W-1:0] sel);
        @(posedge clock);
        reset_n      <= 1'b0;
        ratio_select <= sel;
        repeat (8) @(posedge clock);
        #1;
        chk("outputs_in_reset", 32'h0, 32'({iface_clock, cpu_bus_request_q, cpu_owns_bus_q, ad_oe_q,
            cmd_oe_q, cpu_drive_valid_q, pipe_mult, ref_div}));
        @(posedge clock);
        reset_n <= 1'b1;
        repeat (8) @(posedge clock);
        #1;
    endtask : cold_reset

    // Every narrow code once; code 01 is reserved on the fast grade
    task automatic test_ratio();
        logic [SEL_W-1:0] code [4] = '{3'h0, 3'h1, 3'h3, 3'h2};
        logic [5:0]       exp  [4] = '{6'h18, 6'h27, 6'h16, 6'h14};
        for (int k = 0; k < 4; k++) begin
            cold_reset(code[k]);
            chk("ratio_bad", 32'(exp[k][0]), 32'(ratio_bad_q));
            if (!exp[k][0]) chk("ratio_terms", 32'(exp[k][5:1]), 32'({ref_div, pipe_mult}));
        end
    endtask : test_ratio

    task automatic test_clock();
        repeat (6) begin
            @(posedge clock);
            #1;
            chk("iface_clock", 32'(edges[0]), 32'(iface_clock));
            chk("deskew_out", 32'(edges[0]), 32'(deskew_clk_out));
        end
    endtask : test_clock

    // Two-word transfer with a slow grant; valid may only stand while the bus is driven
    task automatic test_tx();
        agt.accept_lat = 5;
        @(posedge clock);
        tx_valid <= 1'b1;
        tx_word  <= 32'h1234_5678;
        tx_cmd   <= 5'h0A;
        tx_last  <= 1'b0;
        wait_on(0, 20);
        chk("owner_before_grant", 32'h0, 32'(cpu_owns_bus_q));
        wait_on(1, 40);
        chk("word0", 32'h1234_5678, ad_out_q);
        chk("cmd0", 32'h0A, 32'(cmd_out_q));
        chk("drive_flags0", 32'hF, 32'({cpu_owns_bus_q, ad_oe_q, cmd_oe_q, cpu_drive_valid_q}));
        @(posedge clock);
        tx_word <= 32'hFEDC_BA98;
        tx_cmd  <= 5'h1F;
        tx_last <= 1'b1;
        wait_on(1, 4);
        chk("word1", 32'hFEDC_BA98, ad_out_q);
        chk("cmd1", 32'h1F, 32'(cmd_out_q));
        @(posedge clock);
        tx_valid <= 1'b0;
        repeat (8) begin
            @(posedge clock);
            #1;
            chk("valid_without_drive", 32'h0, 32'(cpu_drive_valid_q & ~ad_oe_q));
        end
        chk("released", 32'h0, 32'({cpu_owns_bus_q, ad_oe_q, cmd_oe_q, cpu_drive_valid_q}));
    endtask : test_tx

    task automatic test_rx();
        int n = 0;
        agt.send(32'hA5C3_0F12, 5'h1B, 1'b0);
        wait_on(3, 6);
        chk("rx_word", 32'hA5C3_0F12, rx_word_q);
        chk("rx_cmd", 32'h1B, 32'(rx_cmd_q));
        repeat (6) begin
            @(posedge clock);
            #1;
            n += int'(rx_valid_q === 1'b1);
        end
        chk("rx_single", 32'h0, 32'(n));
    endtask : test_rx

    // Levels pass unmasked to the cause bits; the mask gates only the pending flag
    task automatic test_irq();
        @(posedge clock);
        int_req <= 5'h15;
        repeat (5) @(posedge clock);
        #1;
        chk("cause_bits", 32'h15, 32'(cause_ip_q));
        chk("pending_masked", 32'h0, 32'(int_pending_q));
        @(posedge clock);
        int_mask <= 5'h04;
        repeat (3) @(posedge clock);
        #1;
        chk("pending_open", 32'h1, 32'(int_pending_q));
        @(posedge clock);
        int_mask <= 5'h00;
        nmi_req  <= 1'b1;
        wait_on(4, 8);
        @(posedge clock);
        #1;
        chk("nmi_one_pulse", 32'h0, 32'(nmi_event_q));
        @(posedge clock);
        nmi_req <= 1'b0;
    endtask : test_irq

    task automatic test_warm();
        @(posedge clock);
        warm_reset_n <= 1'b0;
        wait_on(5, 8);
        chk("state_kept", 32'hA5C3_0F12, rx_word_q);
        chk("cause_kept", 32'h15, 32'(cause_ip_q));
        @(posedge clock);
        warm_reset_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : test_warm

    // Agent drives while the processor owns: request must oscillate and takes stop
    task automatic test_error();
        int   flips = 0;
        int   takes = 0;
        logic last;
        agt.accept_lat = 0;
        @(posedge clock);
        tx_valid <= 1'b1;
        tx_last  <= 1'b0;
        wait_on(2, 20);
        agt.send(32'h0BAD_0BAD, 5'h03, 1'b1);
        wait_on(6, 12);
        last = cpu_bus_request_q;
        repeat (8) begin
            @(posedge clock);
            #1;
            flips += int'(cpu_bus_request_q !== last);
            takes += int'(tx_take_q === 1'b1);
            last = cpu_bus_request_q;
        end
        chk("request_flips", 32'h4, 32'(flips));
        chk("halted_takes", 32'h0, 32'(takes));
        @(posedge clock);
        tx_valid <= 1'b0;
    endtask : test_error

    task automatic print_verdict();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        test_ratio();
        test_clock();
        test_tx();
        test_rx();
        test_irq();
        test_warm();
        test_error();
        print_verdict();
    end
endmodule : cbc_top_bench
